/* File: eeprom_access_ctrl.sv */
/*
  Data eeprom access control: three byte registers, a 128 byte array, and a
  sequencer for read and erase-then-program cycles.
  Assumes the register port comes from processor logic on clk_sys.
*/
module eeprom_access_ctrl
  import eeprom_access_pkg::*;
#(
  parameter int ERASE_CNT = ERASE_CYCLES,
  parameter int PROG_CNT = PROG_CYCLES
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic clk_en,
  input wire eeprom_access_pkg::reg_req_t req,
  output logic [7:0] rdata,
  output logic array_busy
);
  import eeprom_access_pkg::*;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [7:0] mem_q [DEPTH];
  ee_state_t state_q;
  logic [15:0] cnt_q;
  logic read_trig_q;
  logic write_trig_q;
  logic array_write_enable_q;
  logic write_busy_flag_q;
  logic array_power_control_q;
  logic [ADDR_W-1:0] addr_q;
  logic [7:0] data_q;
  logic [7:0] ctrl_view;
  logic ctrl_wr;
  logic addr_wr;
  logic data_wr;
  logic start_rd;
  logic start_wr;
  logic refuse_wr;
  logic seq_done;

  assign ctrl_wr = req.wr && (req.addr == CTRL_OFFSET);
  assign addr_wr = req.wr && (req.addr == ADDR_OFFSET);
  assign data_wr = req.wr && (req.addr == DATA_OFFSET);

  assign ctrl_view = {read_trig_q, write_trig_q, array_write_enable_q,
                      write_busy_flag_q, array_power_control_q, 3'b000};

  // ----------------------------------------------------------------
  // start decisions
  // ----------------------------------------------------------------
  // start only from idle, with a trigger and the power bit set; a read trigger wins over a write
  assign start_rd = (state_q == ST_IDLE) && read_trig_q && array_power_control_q;
  assign start_wr = (state_q == ST_IDLE) && !read_trig_q && write_trig_q &&
                    array_write_enable_q && array_power_control_q;
  assign refuse_wr = (state_q == ST_IDLE) && !read_trig_q && write_trig_q &&
                     !(array_write_enable_q && array_power_control_q);
  assign seq_done = (cnt_q == 16'h0000);

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      state_q <= ST_IDLE;
      cnt_q <= 16'h0000;
    end else if (clk_en) begin
      case (state_q)
        ST_IDLE: begin
          if (start_rd) begin
            state_q <= ST_READ;
          end else if (start_wr) begin
            state_q <= ST_ERASE;
            cnt_q <= 16'(ERASE_CNT - 1);
          end
        end
        ST_READ: begin
          state_q <= ST_IDLE;
        end
        ST_ERASE: begin
          if (seq_done) begin
            state_q <= ST_PROG;
            cnt_q <= 16'(PROG_CNT - 1);
          end else begin
            cnt_q <= cnt_q - 16'h0001;
          end
        end
        ST_PROG: begin
          if (seq_done) begin
            state_q <= ST_IDLE;
          end else begin
            cnt_q <= cnt_q - 16'h0001;
          end
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // array
  // ----------------------------------------------------------------
  // no reset on the array: it models non-volatile content
  always_ff @(posedge clk_sys) begin
    if (clk_en) begin
      if (state_q == ST_ERASE && seq_done) begin
        mem_q[addr_q] <= ERASED_BYTE;
      end else if (state_q == ST_PROG && seq_done) begin
        mem_q[addr_q] <= data_q;
      end
    end
  end

  // ----------------------------------------------------------------
  // control register
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      {read_trig_q, write_trig_q, array_write_enable_q,
       write_busy_flag_q, array_power_control_q} <= CTRL_RESET[7:3];
    end else if (clk_en) begin
      if (ctrl_wr) begin
        array_write_enable_q <= req.wdata[WE_BIT];
        array_power_control_q <= req.wdata[POWER_BIT];
      end
      if (state_q == ST_READ) begin
        read_trig_q <= 1'b0;
      end else if (ctrl_wr && req.wdata[READ_TRIG_BIT]) begin
        read_trig_q <= 1'b1;
      end else if (start_rd == 1'b0 && !array_power_control_q) begin
        read_trig_q <= 1'b0;
      end
      if ((state_q == ST_PROG && seq_done) || refuse_wr) begin
        write_trig_q <= 1'b0;
      end else if (ctrl_wr && req.wdata[WRITE_TRIG_BIT]) begin
        write_trig_q <= 1'b1;
      end
      if (start_wr) begin
        write_busy_flag_q <= 1'b1;
      end else if (state_q == ST_PROG && seq_done) begin
        write_busy_flag_q <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // address and data registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      addr_q <= ADDR_RESET[ADDR_W-1:0];
      data_q <= DATA_RESET;
    end else if (clk_en) begin
      if (addr_wr && state_q == ST_IDLE) begin
        addr_q <= req.wdata[ADDR_W-1:0];
      end
      if (state_q == ST_READ) begin
        data_q <= mem_q[addr_q];
      end else if (data_wr && state_q == ST_IDLE) begin
        data_q <= req.wdata;
      end
    end
  end

  // ----------------------------------------------------------------
  // read port
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      rdata <= 8'h00;
    end else if (clk_en && req.rd) begin
      case (req.addr)
        CTRL_OFFSET: rdata <= ctrl_view;
        ADDR_OFFSET: rdata <= {1'b0, addr_q};
        DATA_OFFSET: rdata <= data_q;
        default: rdata <= 8'h00;
      endcase
    end
  end

  assign array_busy = write_busy_flag_q;

endmodule : eeprom_access_ctrl

/* File: eeprom_access_ctrl_properties.sv */
/* port checker for eeprom_access_ctrl.
   assumes clk_en stays high while an array cycle runs. */
module eeprom_access_ctrl_properties
  import eeprom_access_pkg::*;
#(
  parameter int ERASE_CNT = 2,
  parameter int PROG_CNT = 2
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic clk_en,
  input wire eeprom_access_pkg::reg_req_t req,
  input wire logic [7:0] rdata,
  input wire logic array_busy
);
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  default clocking @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  int busy_cnt_q;
  always_ff @(posedge clk_sys) busy_cnt_q <= array_busy ? busy_cnt_q + 1 : 0;
  sequence rd_at(a);
    req.rd && clk_en && req.addr == a;
  endsequence
  sequence ctrl_trig;
    req.wr && clk_en && req.addr == CTRL_OFFSET && req.wdata[6] && !array_busy;
  endsequence
  // ----------------------------------------
  // properties
  // ----------------------------------------
  // busy length
  busy_len_a: assert property ($fell(array_busy) && !$past(sys_rst) |->
    busy_cnt_q == ERASE_CNT + PROG_CNT) else $error("busy length wrong");
  busy_cause_a: assert property ($rose(array_busy) && !$past(sys_rst) |->
    $past(req.wr && req.addr == CTRL_OFFSET && req.wdata[6:5] == 2'h3 && req.wdata[3], 2))
    else $error("busy without enabled trigger");
  busy_start_a: assert property (ctrl_trig ##0 req.wdata[7:3] == 5'h0d |-> ##2 array_busy)
    else $error("write cycle not started");
  refused_write_a: assert property (ctrl_trig ##0 !(req.wdata[5] && req.wdata[3])
    |=> !array_busy [*2]) else $error("refused write set busy");
  low_bits_a: assert property (rd_at(CTRL_OFFSET) |=> rdata[2:0] == 3'h0)
    else $error("control low bits not zero");
  addr_msb_a: assert property (rd_at(ADDR_OFFSET) |=> !rdata[7])
    else $error("address bit 7 not zero");
  busy_mirror_a: assert property (rd_at(CTRL_OFFSET) |=>
    rdata[BUSY_BIT] == $past(array_busy)) else $error("busy bit differs from pin");
  rdata_hold_a: assert property (!(req.rd && clk_en) |=> $stable(rdata))
    else $error("read data moved without read");
endmodule : eeprom_access_ctrl_properties

bind eeprom_access_ctrl eeprom_access_ctrl_properties #(.ERASE_CNT(ERASE_CNT),
  .PROG_CNT(PROG_CNT)) props (.clk_sys(clk_sys), .sys_rst(sys_rst), .clk_en(clk_en),
  .req(req), .rdata(rdata), .array_busy(array_busy));

/* File: eeprom_access_pkg.sv */
/*
  Shared constants and carrier types for the data eeprom access control block.
  Assumes a byte-wide processor register port on a single clk_sys domain.
*/
package eeprom_access_pkg;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [7:0] CTRL_OFFSET = 8'h0b;
  localparam logic [7:0] ADDR_OFFSET = 8'h0c;
  localparam logic [7:0] DATA_OFFSET = 8'h0d;

  // ----------------------------------------------------------------
  // control field positions and reset values
  // ----------------------------------------------------------------
  localparam int READ_TRIG_BIT = 7;
  localparam int WRITE_TRIG_BIT = 6;
  localparam int WE_BIT = 5;
  localparam int BUSY_BIT = 4;
  localparam int POWER_BIT = 3;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] ADDR_RESET = 8'h00;
  localparam logic [7:0] DATA_RESET = 8'h00;
  localparam int ADDR_W = 7;
  localparam int DEPTH = 128;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int ERASE_TIME_NS = 1000;
  localparam int PROG_TIME_NS = 1000;
  localparam int ERASE_CYCLES = (ERASE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PROG_CYCLES = (PROG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [7:0] ERASED_BYTE = 8'hff;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_t;

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_READ = 4'b0010,
    ST_ERASE = 4'b0100,
    ST_PROG = 4'b1000
  } ee_state_t;

endpackage : eeprom_access_pkg

/* File: test_data_eeprom_access_control.sv */
/* self-checking bench for eeprom_access_ctrl.
   assumes short erase and program counts of 2 cycles each. */
module test_data_eeprom_access_control;
  timeunit 1ns;
  timeprecision 1ns;
  import eeprom_access_pkg::*;
  logic clk_sys = 0, sys_rst = 1, clk_en = 1, pend = 0, array_busy;
  reg_req_t req = '0;
  logic [7:0] rdata, q[$], mem[128];
  logic [6:0] a;
  int miscompares = 0, cmp_count = 0, seed = 73004;
  eeprom_access_ctrl #(.ERASE_CNT(2), .PROG_CNT(2)) dut (.clk_sys(clk_sys),
    .sys_rst(sys_rst), .clk_en(clk_en), .req(req), .rdata(rdata), .array_busy(array_busy));
  initial forever #5 clk_sys = ~clk_sys;
  // ----------------------------------------
  // bus tasks
  // ----------------------------------------
  task automatic idle(int n);
    req = '0;
    repeat (n) @(negedge clk_sys);
  endtask : idle
  task automatic wr(logic [7:0] ad, logic [7:0] d);
    req = '{1'b1, 1'b0, ad, d};
    @(negedge clk_sys);
  endtask : wr
  task automatic rd(logic [7:0] ad, logic [7:0] e);
    q.push_back(e);
    req = '{1'b0, 1'b1, ad, 8'h00};
    @(negedge clk_sys);
  endtask : rd
  task automatic cmp8(logic [7:0] e);
    cmp_count++;
    if (rdata !== e) begin
      miscompares++;
      $display("ERROR t=%0t got %h exp %h", $time, rdata, e);
    end
  endtask : cmp8
  // read data shows the cycle after the strobe is taken
  always @(posedge clk_sys) pend <= req.rd && clk_en && !sys_rst;
  always @(negedge clk_sys) if (pend) cmp8(q.pop_front());
  task automatic ee_wr(logic [7:0] d);
    wr(CTRL_OFFSET, 8'h08);
    wr(ADDR_OFFSET, {1'b0, a});
    wr(CTRL_OFFSET, 8'h28);
    wr(DATA_OFFSET, d);
    wr(CTRL_OFFSET, 8'h68);
    idle(1);
    rd(CTRL_OFFSET, 8'h78);
    wr(ADDR_OFFSET, {1'b1, ~a});
    idle(1);
    for (int i = 0; i < 50 && array_busy === 1'b1; i++) @(negedge clk_sys);
    rd(CTRL_OFFSET, 8'h28);
    rd(ADDR_OFFSET, {1'b0, a});
    mem[a] = d;
  endtask : ee_wr
  task automatic ee_rd();
    wr(CTRL_OFFSET, 8'h08);
    wr(ADDR_OFFSET, {1'b0, a});
    wr(CTRL_OFFSET, 8'h88);
    idle(2);
    rd(CTRL_OFFSET, 8'h08);
    rd(DATA_OFFSET, mem[a]);
  endtask : ee_rd
  task automatic conclude();
    idle(3);
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : conclude
  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    #20000;
    miscompares++;
    conclude();
  end
  initial begin
    repeat (8) @(negedge clk_sys);
    sys_rst = 0;
    rd(CTRL_OFFSET, CTRL_RESET);
    rd(ADDR_OFFSET, ADDR_RESET);
    rd(DATA_OFFSET, DATA_RESET);
    rd(8'h0e, 8'h00);
    wr(CTRL_OFFSET, 8'h17);
    wr(ADDR_OFFSET, 8'hff);
    rd(CTRL_OFFSET, 8'h00);
    rd(ADDR_OFFSET, 8'h7f);
    clk_en = 0;
    wr(ADDR_OFFSET, 8'h11);
    clk_en = 1;
    rd(ADDR_OFFSET, 8'h7f);
    idle(1);
    $display("register test done");
    for (int i = 0; i < 4; i++) begin
      a = i == 0 ? 7'h00 : i == 1 ? 7'h7f : 7'($random(seed));
      ee_wr(8'($random(seed)));
      ee_rd();
    end
    ee_wr(~mem[a]);
    ee_rd();
    $display("array test done");
    wr(DATA_OFFSET, ~mem[a]);
    wr(CTRL_OFFSET, 8'h48);
    idle(1);
    rd(CTRL_OFFSET, 8'h08);
    wr(CTRL_OFFSET, 8'h60);
    idle(1);
    rd(CTRL_OFFSET, 8'h20);
    wr(CTRL_OFFSET, 8'h80);
    idle(2);
    rd(CTRL_OFFSET, 8'h00);
    rd(DATA_OFFSET, ~mem[a]);
    ee_rd();
    $display("refusal test done");
    conclude();
  end
endmodule : test_data_eeprom_access_control
